// [logic/nfcf_codec.v]
// nfc frame codec: tx encoder, rx decoder, spi host port, shared fifo
//
// Contract
// RULE_01: tx encoder frames by selected rf mode options and bit rate.
// RULE_02: normal mode adds start, stop, parity, crc and end marker itself.
// RULE_03: tx payload bytes are popped from the shared fifo.
// RULE_04: stream mode sends fifo bits straight to modulation, no framing.
// RULE_05: transparent mode passes mosi straight to tx modulation.
// RULE_06: rx decoder deframes by mode and rate, stores bytes in fifo.
// RULE_07: stream mode packs raw sampled subcarrier bits into the fifo.
// RULE_08: transparent mode drives synced subcarrier straight onto miso.
// RULE_09: one 512 byte fifo, holding rx or tx data by direction.
// RULE_10: tx frames up to 8191 bytes, rx frames of any length.
// RULE_11: i2c enable pin selects which host interface owns shared pins.
// RULE_12: exactly one of normal, stream, transparent governs both paths.
`timescale 1ns/1ps
`include "nfcf_defs.vh"
module nfcf_codec #(
    parameter BIT_BASE = `NFCF_BIT_BASE
) (
    input  wire                   mclk_i,
    input  wire                   resetn_i,
    input  wire                   i2c_en_i,
    input  wire                   spi_ss_n_i,
    input  wire                   sclk_i,
    input  wire                   mosi_i,
    output reg                    miso_o,
    output reg                    miso_oe_o,
    input  wire [1:0]             mode_i,
    input  wire                   dir_tx_i,
    input  wire [1:0]             rate_i,
    input  wire                   parity_en_i,
    input  wire                   crc_en_i,
    input  wire                   tx_start_i,
    input  wire [`NFCF_LEN_W-1:0] tx_len_i,
    input  wire                   rx_sub_i,
    output reg                    tx_mod_o,
    output reg                    tx_busy_o,
    output reg                    rx_byte_o,
    output reg                    rx_eof_o,
    output reg                    rx_par_err_o,
    output reg                    rx_overflow_o
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function [15:0] crc_upd;
        input [15:0] c;
        input [7:0]  d;
        integer      i;
        reg   [15:0] r;
        begin
            r = c;
            for (i = 0; i < 8; i = i + 1) begin
                if (r[15] ^ d[7-i])
                    r = {r[14:0], 1'b0} ^ `NFCF_CRC_POLY;
                else
                    r = {r[14:0], 1'b0};
            end
            crc_upd = r;
        end
    endfunction

    function odd_par;
        input [7:0] d;
        begin
            odd_par = ~^d;
        end
    endfunction

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    reg [3:0] s1_reg;
    reg [3:0] s2_reg;
    reg       sclk_q_reg;
    reg       rx_q_reg;
    wire      sclk_s = s2_reg[0];
    wire      mosi_s = s2_reg[1];
    wire      ss_n_s = s2_reg[2];
    wire      rx_s   = s2_reg[3];

    always @(posedge mclk_i) begin
        if (!resetn_i) begin
            s1_reg     <= 4'hc;
            s2_reg     <= 4'hc;
            sclk_q_reg <= 1'b0;
            rx_q_reg   <= 1'b1;
        end else begin
            s1_reg     <= {rx_sub_i, spi_ss_n_i, mosi_i, sclk_i};
            s2_reg     <= s1_reg;
            sclk_q_reg <= sclk_s;
            rx_q_reg   <= rx_s;
        end
    end

    wire mode_str = (mode_i == `NFCF_MODE_STREAM);                   // RULE_12
    wire mode_trn = (mode_i == `NFCF_MODE_TRANS);                    // RULE_12
    wire mode_nrm = !mode_str && !mode_trn;                          // RULE_12
    wire [15:0] period = BIT_BASE >> rate_i;                         // RULE_01
    wire [15:0] half   = period >> 1;

    // ----------------------------------------
    // shared fifo
    // ----------------------------------------
    reg        dir_q_reg;
    reg        spi_push_reg;
    reg  [7:0] spi_in_reg;
    reg        rx_push_reg;
    reg  [7:0] rx_byte_reg;
    wire       wr_ready;
    wire       rd_valid;
    wire [7:0] rd_data;
    wire       tx_pop;
    wire       spi_pop;

    nfcf_fifo #(
        .WIDTH (`NFCF_FIFO_WIDTH),
        .DEPTH (`NFCF_FIFO_DEPTH),
        .AW    (`NFCF_FIFO_AW)
    ) u_fifo (                                                       // RULE_09
        .clk_i      (mclk_i),
        .resetn_i   (resetn_i),
        .flush_i    (dir_q_reg != dir_tx_i),
        .wr_valid_i (dir_tx_i ? spi_push_reg : rx_push_reg),
        .wr_data_i  (dir_tx_i ? spi_in_reg : rx_byte_reg),
        .wr_ready_o (wr_ready),
        .rd_valid_o (rd_valid),
        .rd_data_o  (rd_data),
        .rd_ready_i (dir_tx_i ? tx_pop : spi_pop)
    );

    // ----------------------------------------
    // spi host port
    // ----------------------------------------
    reg  [2:0] spi_cnt_reg;
    reg  [7:0] spi_out_reg;
    wire       spi_act = !i2c_en_i && !ss_n_s && !mode_trn;          // RULE_11
    wire       sclk_r  = sclk_s && !sclk_q_reg;
    wire       sclk_f  = !sclk_s && sclk_q_reg;
    reg        ss_q_reg;
    wire       ss_begin = spi_act && ss_q_reg;
    wire       spi_ld  = spi_act && ((spi_cnt_reg == 3'h7 && sclk_r) || ss_begin);
    assign     spi_pop = spi_ld && rd_valid;

    always @(posedge mclk_i) begin
        if (!resetn_i) begin
            ss_q_reg     <= 1'b1;
            spi_cnt_reg  <= 3'h0;
            spi_in_reg   <= 8'h00;
            spi_out_reg  <= 8'h00;
            spi_push_reg <= 1'b0;
            dir_q_reg    <= 1'b0;
            miso_o       <= 1'b0;
            miso_oe_o    <= 1'b0;
        end else begin
            ss_q_reg     <= !spi_act;
            dir_q_reg    <= dir_tx_i;
            spi_push_reg <= 1'b0;
            if (!spi_act) begin
                spi_cnt_reg <= 3'h0;
            end else begin
                if (sclk_r) begin
                    spi_in_reg  <= {spi_in_reg[6:0], mosi_s};
                    spi_cnt_reg <= spi_cnt_reg + 1'b1;
                    if (spi_cnt_reg == 3'h7 && dir_tx_i) begin
                        spi_push_reg <= 1'b1;                        // RULE_09
                    end
                end
                if (sclk_f && spi_cnt_reg != 3'h0) begin
                    spi_out_reg <= {spi_out_reg[6:0], 1'b0};
                end
                if (spi_ld) begin
                    spi_out_reg <= (rd_valid && !dir_tx_i) ? rd_data : 8'h00;
                end
            end
            miso_oe_o <= !i2c_en_i && (!ss_n_s || mode_trn);         // RULE_11
            miso_o    <= mode_trn ? rx_s : spi_out_reg[7];           // RULE_08
        end
    end

    // ----------------------------------------
    // tx encoder
    // ----------------------------------------
    reg [2:0]             t_st_reg;
    reg [15:0]            t_tmr_reg;
    reg [`NFCF_LEN_W-1:0] t_left_reg;
    reg [1:0]             t_crc_reg;
    reg [15:0]            t_crcv_reg;
    reg [7:0]             t_sh_reg;
    reg [2:0]             t_bit_reg;
    reg                   t_par_reg;
    wire                  t_tick = (t_tmr_reg == 16'h0000);
    wire                  t_fifo = (t_st_reg == `NFCF_T_LOAD) && (t_left_reg != {`NFCF_LEN_W{1'b0}});
    assign                tx_pop = t_fifo && rd_valid && dir_tx_i;   // RULE_03

    always @(posedge mclk_i) begin
        if (!resetn_i) begin
            t_st_reg   <= `NFCF_T_IDLE;
            t_tmr_reg  <= 16'h0000;
            t_left_reg <= {`NFCF_LEN_W{1'b0}};
            t_crc_reg  <= 2'h0;
            t_crcv_reg <= `NFCF_CRC_INIT;
            t_sh_reg   <= 8'h00;
            t_bit_reg  <= 3'h0;
            t_par_reg  <= 1'b0;
            tx_mod_o   <= 1'b1;
            tx_busy_o  <= 1'b0;
        end else begin
            t_tmr_reg <= t_tick ? period - 1'b1 : t_tmr_reg - 1'b1;
            tx_busy_o <= (t_st_reg != `NFCF_T_IDLE);
            case (t_st_reg)
                `NFCF_T_IDLE: begin
                    tx_mod_o <= mode_trn ? mosi_s : 1'b1;            // RULE_05
                    if (tx_start_i && dir_tx_i && !mode_trn) begin
                        t_left_reg <= tx_len_i;                      // RULE_10
                        t_crc_reg  <= (crc_en_i && mode_nrm) ? 2'h2 : 2'h0;
                        t_crcv_reg <= `NFCF_CRC_INIT;
                        t_st_reg   <= `NFCF_T_LOAD;
                    end
                end
                `NFCF_T_LOAD: begin
                    t_tmr_reg <= period - 1'b1;
                    t_bit_reg <= 3'h0;
                    if (t_fifo) begin
                        if (tx_pop) begin
                            t_sh_reg   <= rd_data;
                            t_par_reg  <= odd_par(rd_data);          // RULE_02
                            t_crcv_reg <= crc_upd(t_crcv_reg, rd_data);
                            t_left_reg <= t_left_reg - 1'b1;
                            t_st_reg   <= mode_str ? `NFCF_T_DATA : `NFCF_T_START; // RULE_04
                            tx_mod_o   <= mode_str ? rd_data[0] : 1'b0;
                        end
                    end else if (t_crc_reg != 2'h0) begin
                        t_sh_reg  <= (t_crc_reg == 2'h2) ? t_crcv_reg[15:8] : t_crcv_reg[7:0]; // RULE_02
                        t_par_reg <= odd_par((t_crc_reg == 2'h2) ? t_crcv_reg[15:8] : t_crcv_reg[7:0]);
                        t_crc_reg <= t_crc_reg - 1'b1;
                        t_st_reg  <= `NFCF_T_START;
                        tx_mod_o  <= 1'b0;
                    end else begin
                        t_st_reg <= mode_str ? `NFCF_T_IDLE : `NFCF_T_EOF;
                        tx_mod_o <= 1'b1;
                    end
                end
                `NFCF_T_START: begin
                    if (t_tick) begin
                        tx_mod_o <= t_sh_reg[0];
                        t_st_reg <= `NFCF_T_DATA;
                    end
                end
                `NFCF_T_DATA: begin
                    if (t_tick) begin
                        t_sh_reg  <= {1'b0, t_sh_reg[7:1]};
                        t_bit_reg <= t_bit_reg + 1'b1;
                        tx_mod_o  <= t_sh_reg[1];
                        if (t_bit_reg == 3'h7) begin
                            if (mode_str) begin
                                t_st_reg <= `NFCF_T_LOAD;            // RULE_04
                            end else if (parity_en_i) begin
                                tx_mod_o <= t_par_reg;               // RULE_02
                                t_st_reg <= `NFCF_T_PAR;
                            end else begin
                                tx_mod_o <= 1'b1;
                                t_st_reg <= `NFCF_T_STOP;
                            end
                        end
                    end
                end
                `NFCF_T_PAR: begin
                    if (t_tick) begin
                        tx_mod_o <= 1'b1;
                        t_st_reg <= `NFCF_T_STOP;
                    end
                end
                `NFCF_T_STOP: begin
                    if (t_tick) begin
                        t_st_reg <= `NFCF_T_LOAD;
                    end
                end
                `NFCF_T_EOF: begin
                    if (t_tick) begin
                        t_bit_reg <= t_bit_reg + 1'b1;
                        if (t_bit_reg == `NFCF_EOF_BITS - 1'b1) begin // RULE_02
                            t_st_reg <= `NFCF_T_IDLE;
                        end
                    end
                end
                default: t_st_reg <= `NFCF_T_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // rx decoder
    // ----------------------------------------
    reg [2:0]  r_st_reg;
    reg [15:0] r_tmr_reg;
    reg [3:0]  r_bit_reg;
    wire       r_tick = (r_tmr_reg == 16'h0000);
    wire       r_fall = !rx_s && rx_q_reg;
    wire       r_on   = !dir_tx_i && !mode_trn;                      // RULE_08

    always @(posedge mclk_i) begin
        if (!resetn_i) begin
            r_st_reg      <= `NFCF_R_IDLE;
            r_tmr_reg     <= 16'h0000;
            r_bit_reg     <= 4'h0;
            rx_byte_reg   <= 8'h00;
            rx_push_reg   <= 1'b0;
            rx_byte_o     <= 1'b0;
            rx_eof_o      <= 1'b0;
            rx_par_err_o  <= 1'b0;
            rx_overflow_o <= 1'b0;
        end else begin
            r_tmr_reg   <= r_tick ? period - 1'b1 : r_tmr_reg - 1'b1;
            rx_push_reg <= 1'b0;
            rx_byte_o   <= 1'b0;
            rx_eof_o    <= 1'b0;
            if (dir_tx_i) begin
                rx_overflow_o <= 1'b0;
                rx_par_err_o  <= 1'b0;
            end else if (rx_push_reg && !wr_ready) begin
                rx_overflow_o <= 1'b1;
            end
            if (!r_on) begin
                r_st_reg <= `NFCF_R_IDLE;
            end else begin
                case (r_st_reg)
                    `NFCF_R_IDLE, `NFCF_R_GAP: begin
                        if (mode_str) begin
                            r_st_reg  <= `NFCF_R_STREAM;             // RULE_07
                            r_bit_reg <= 4'h0;
                        end else if (r_fall) begin
                            r_tmr_reg <= half - 1'b1;
                            r_st_reg  <= `NFCF_R_START;
                        end else if (r_st_reg == `NFCF_R_GAP && r_tick) begin
                            r_bit_reg <= r_bit_reg + 1'b1;
                            if (r_bit_reg == {1'b0, `NFCF_EOF_BITS} - 1'b1) begin
                                rx_eof_o <= 1'b1;                    // RULE_10
                                r_st_reg <= `NFCF_R_IDLE;
                            end
                        end
                    end
                    `NFCF_R_START: begin
                        r_bit_reg <= 4'h0;
                        if (r_tick) begin
                            r_st_reg <= rx_s ? `NFCF_R_GAP : `NFCF_R_DATA;
                        end
                    end
                    `NFCF_R_DATA: begin
                        if (r_tick) begin
                            rx_byte_reg <= {rx_s, rx_byte_reg[7:1]}; // RULE_06
                            r_bit_reg   <= r_bit_reg + 1'b1;
                            if (r_bit_reg == 4'h7) begin
                                r_st_reg <= parity_en_i ? `NFCF_R_PAR : `NFCF_R_STOP;
                            end
                        end
                    end
                    `NFCF_R_PAR: begin
                        if (r_tick) begin
                            if (rx_s != odd_par(rx_byte_reg)) begin
                                rx_par_err_o <= 1'b1;
                            end
                            r_st_reg <= `NFCF_R_STOP;
                        end
                    end
                    `NFCF_R_STOP: begin
                        if (r_tick) begin
                            rx_push_reg <= 1'b1;                     // RULE_06
                            rx_byte_o   <= 1'b1;
                            r_bit_reg   <= 4'h0;
                            r_st_reg    <= `NFCF_R_GAP;
                        end
                    end
                    `NFCF_R_STREAM: begin
                        if (!mode_str) begin
                            r_st_reg <= `NFCF_R_IDLE;
                        end else if (r_tick) begin
                            rx_byte_reg <= {rx_s, rx_byte_reg[7:1]}; // RULE_07
                            r_bit_reg   <= {1'b0, r_bit_reg[2:0] + 3'h1};
                            if (r_bit_reg[2:0] == 3'h7) begin
                                rx_push_reg <= 1'b1;
                                rx_byte_o   <= 1'b1;
                            end
                        end
                    end
                    default: r_st_reg <= `NFCF_R_IDLE;
                endcase
            end
        end
    end
endmodule // nfcf_codec

// [logic/nfcf_defs.vh]
// constants shared by the frame codec and its fifo
`ifndef NFCF_DEFS_VH
`define NFCF_DEFS_VH

// datapath modes
`define NFCF_MODE_NORMAL  2'h0
`define NFCF_MODE_STREAM  2'h1
`define NFCF_MODE_TRANS   2'h2

// fifo geometry
`define NFCF_FIFO_WIDTH   8
`define NFCF_FIFO_DEPTH   512
`define NFCF_FIFO_AW      9

// transmit frame length field
`define NFCF_LEN_W        13

// bit timing in mclk cycles at the base rate
`define NFCF_BIT_BASE     16'h03b0
`define NFCF_EOF_BITS     4'h3

// crc-16
`define NFCF_CRC_POLY     16'h1021
`define NFCF_CRC_INIT     16'hffff

// transmit states
`define NFCF_T_IDLE       3'h0
`define NFCF_T_LOAD       3'h1
`define NFCF_T_START      3'h2
`define NFCF_T_DATA       3'h3
`define NFCF_T_PAR        3'h4
`define NFCF_T_STOP       3'h5
`define NFCF_T_EOF        3'h6

// receive states
`define NFCF_R_IDLE       3'h0
`define NFCF_R_START      3'h1
`define NFCF_R_DATA       3'h2
`define NFCF_R_PAR        3'h3
`define NFCF_R_STOP       3'h4
`define NFCF_R_GAP        3'h5
`define NFCF_R_STREAM     3'h6

`endif

// [logic/nfcf_fifo.v]
// shared byte fifo with valid/ready on both sides
`timescale 1ns/1ps
module nfcf_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 512,
    parameter AW    = 9
) (
    input  wire             clk_i,
    input  wire             resetn_i,
    input  wire             flush_i,
    input  wire             wr_valid_i,
    input  wire [WIDTH-1:0] wr_data_i,
    output wire             wr_ready_o,
    output wire             rd_valid_o,
    output wire [WIDTH-1:0] rd_data_o,
    input  wire             rd_ready_i
);
    reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
    reg [AW-1:0]    wptr_reg;
    reg [AW-1:0]    rptr_reg;
    reg [AW:0]      cnt_reg;
    wire            do_wr;
    wire            do_rd;

    assign wr_ready_o = (cnt_reg != DEPTH[AW:0]);
    assign rd_valid_o = (cnt_reg != {(AW+1){1'b0}});
    assign rd_data_o  = mem_reg[rptr_reg];
    assign do_wr      = wr_valid_i & wr_ready_o;
    assign do_rd      = rd_ready_i & rd_valid_o;

    // ----------------------------------------
    // storage and pointers
    // ----------------------------------------
    always @(posedge clk_i) begin
        if (do_wr) begin
            mem_reg[wptr_reg] <= wr_data_i;
        end
    end

    always @(posedge clk_i) begin
        if (!resetn_i || flush_i) begin
            wptr_reg <= {AW{1'b0}};
            rptr_reg <= {AW{1'b0}};
            cnt_reg  <= {(AW+1){1'b0}};
        end else begin
            if (do_wr) begin
                wptr_reg <= (wptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wptr_reg + 1'b1;
            end
            if (do_rd) begin
                rptr_reg <= (rptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rptr_reg + 1'b1;
            end
            if (do_wr && !do_rd) begin
                cnt_reg <= cnt_reg + 1'b1;
            end else if (do_rd && !do_wr) begin
                cnt_reg <= cnt_reg - 1'b1;
            end
        end
    end
endmodule // nfcf_fifo

// [verif/nfcf_codec_sva.sv]
// assertion checker on the frame codec ports
`timescale 1ns/1ps
`include "nfcf_defs.vh"
module nfcf_codec_sva #(
    parameter BIT_BASE = `NFCF_BIT_BASE
) (
    input wire       mclk_i,
    input wire       resetn_i,
    input wire       i2c_en_i,
    input wire       mosi_i,
    input wire       miso_o,
    input wire       miso_oe_o,
    input wire [1:0] mode_i,
    input wire       dir_tx_i,
    input wire       tx_start_i,
    input wire       rx_sub_i,
    input wire       tx_mod_o,
    input wire       tx_busy_o,
    input wire       rx_byte_o,
    input wire       rx_eof_o,
    input wire       rx_par_err_o,
    input wire       rx_overflow_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);
    property p_trans_tx; (resetn_i && mode_i == 2'h2 && $stable(mosi_i))[*5] |-> tx_mod_o == mosi_i; endproperty
    a_trans_tx: assert property (p_trans_tx) else $error("tx_mod not following mosi");
    property p_trans_rx;
        (resetn_i && mode_i == 2'h2 && !i2c_en_i && $stable(rx_sub_i))[*6] |-> miso_o == rx_sub_i && miso_oe_o;
    endproperty
    a_trans_rx: assert property (p_trans_rx) else $error("miso not following rx");
    property p_i2c_off; i2c_en_i[*2] |-> !miso_oe_o; endproperty
    a_i2c_off: assert property (p_i2c_off) else $error("miso driven in i2c");
    property p_tx_go; tx_start_i && !tx_busy_o && dir_tx_i && mode_i != 2'h2 |-> ##[1:3] tx_busy_o; endproperty
    a_tx_go: assert property (p_tx_go) else $error("tx start ignored");
    property p_trans_stay; tx_start_i && !tx_busy_o && mode_i == 2'h2 |=> !tx_busy_o[*3]; endproperty
    a_trans_stay: assert property (p_trans_stay) else $error("tx ran in transparent");
    property p_idle_high; (!tx_busy_o && mode_i != 2'h2)[*4] |-> tx_mod_o; endproperty
    a_idle_high: assert property (p_idle_high) else $error("idle line modulated");
    property p_flag_clr; dir_tx_i[*2] |-> !rx_overflow_o && !rx_par_err_o; endproperty
    a_flag_clr: assert property (p_flag_clr) else $error("rx flags not cleared");
    property p_ovf_keep; rx_overflow_o && !dir_tx_i |=> rx_overflow_o; endproperty
    a_ovf_keep: assert property (p_ovf_keep) else $error("overflow lost");
    property p_byte_gap; rx_byte_o |-> !rx_eof_o[*4]; endproperty
    a_byte_gap: assert property (p_byte_gap) else $error("eof too early");
    c_eof: cover property (rx_eof_o);
    c_ovf: cover property ($rose(rx_overflow_o));
    c_tx_end: cover property ($fell(tx_busy_o));
    c_trans: cover property (mode_i == 2'h2 && miso_oe_o);
endmodule // nfcf_codec_sva

bind nfcf_codec nfcf_codec_sva #(.BIT_BASE(BIT_BASE)) chk_u (.*);

// [verif/nfcf_spi_host.sv]
// spi host model on the shared host pins
`timescale 1ns/1ps
module nfcf_spi_host (
    input  wire mclk_i,
    input  wire miso_i,
    output reg  ss_n_o,
    output reg  sclk_o,
    output reg  mosi_o
);
    integer i;
    initial begin
        ss_n_o = 1'b1;
        sclk_o = 1'b0;
        mosi_o = 1'b0;
    end
    // one byte per select frame, mode 0, msb first, sclk still between frames
    task xfer(input [7:0] d, output [7:0] q);
        begin
            @(negedge mclk_i);
            ss_n_o = 1'b0;
            for (i = 7; i >= 0; i = i - 1) begin
                mosi_o = d[i];
                repeat (8) @(negedge mclk_i);
                q[i] = miso_i;
                sclk_o = 1'b1;
                repeat (8) @(negedge mclk_i);
                sclk_o = 1'b0;
            end
            repeat (8) @(negedge mclk_i);
            ss_n_o = 1'b1;
            mosi_o = ~mosi_o;
            repeat (8) @(negedge mclk_i);
        end
    endtask
endmodule // nfcf_spi_host

// [verif/tb_nfcf_codec.sv]
// bench for the frame codec: tx, transparent, rx fill and stream tx paths
`timescale 1ns/1ps
`include "nfcf_defs.vh"
module tb_nfcf_codec;
    reg         mclk_i = 1'b0;
    reg         resetn_i = 1'b0;
    reg         i2c_en_i = 1'b0;
    reg         mosi_t = 1'b0;
    reg         rx_sub_i = 1'b1;
    reg  [1:0]  mode_i = 2'h0;
    reg  [1:0]  rate_i = 2'h0;
    reg         dir_tx_i = 1'b1;
    reg         tx_start_i = 1'b0, crc_en_i = 1'b1;
    reg  [12:0] tx_len_i = 13'h0;
    reg  [31:0] seed = 32'h45;
    reg  [15:0] crc;
    reg  [7:0]  b, r;
    reg  [7:0]  fq[$];
    reg         eb[$];
    integer     err_total = 0, n_checks = 0, cyc = 0, nrx = 0, j, k;
    wire        spi_ss_n_i, sclk_i, mosi_h, miso_o, miso_oe_o, tx_mod_o;
    wire        tx_busy_o, rx_byte_o, rx_eof_o, rx_par_err_o, rx_overflow_o;
    wire        mosi_i = (mode_i == 2'h2) ? mosi_t : mosi_h;

    nfcf_codec #(.BIT_BASE(16'h0010)) dut_u (.mclk_i(mclk_i), .resetn_i(resetn_i), .i2c_en_i(i2c_en_i),
        .spi_ss_n_i(spi_ss_n_i), .sclk_i(sclk_i), .mosi_i(mosi_i), .miso_o(miso_o), .miso_oe_o(miso_oe_o),
        .mode_i(mode_i), .dir_tx_i(dir_tx_i), .rate_i(rate_i), .parity_en_i(1'b1), .crc_en_i(crc_en_i),
        .tx_start_i(tx_start_i), .tx_len_i(tx_len_i), .rx_sub_i(rx_sub_i), .tx_mod_o(tx_mod_o),
        .tx_busy_o(tx_busy_o), .rx_byte_o(rx_byte_o), .rx_eof_o(rx_eof_o), .rx_par_err_o(rx_par_err_o),
        .rx_overflow_o(rx_overflow_o));
    nfcf_spi_host host_u (.mclk_i(mclk_i), .miso_i(miso_o), .ss_n_o(spi_ss_n_i), .sclk_o(sclk_i), .mosi_o(mosi_h));

    always #5 mclk_i = ~mclk_i;
    always @(posedge mclk_i) begin
        cyc = cyc + 1;
        if (rx_byte_o === 1'b1)
            nrx = nrx + 1;
        if (cyc == 30000) begin
            err_total = err_total + 1;
            stop_test;
        end
    end
    function [7:0] nxt();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        nxt = seed[7:0];
    endfunction
    task chk(input [15:0] got, input [15:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    // expected line bits of one framed byte
    task addb(input [7:0] v);
        begin
            eb.push_back(1'b0);
            for (k = 0; k < 8; k = k + 1)
                eb.push_back(v[k]);
            eb.push_back(~^v);
            eb.push_back(1'b1);
        end
    endtask
    task crcb(input [7:0] v);
        for (k = 7; k >= 0; k = k - 1)
            crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ v[k]) ? `NFCF_CRC_POLY : 16'h0000);
    endtask
    task rxb(input [10:0] v);
        for (k = 0; k < 11; k = k + 1) begin
            rx_sub_i = v[k];
            repeat (2) @(negedge mclk_i);
        end
    endtask
    task go(input [12:0] n);
        begin
            tx_len_i = n;
            tx_start_i = 1'b1;
            @(negedge mclk_i);
            tx_start_i = 1'b0;
        end
    endtask
    task to_low;
        for (k = 0; k < 3000 && tx_mod_o !== 1'b0; k = k + 1)
            @(negedge mclk_i);
    endtask
    task stop_test;
        begin
            $display("checks=%0d mismatches=%0d", n_checks, err_total);
            if (err_total == 0 && n_checks > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask

    initial begin
        repeat (2) @(negedge mclk_i);
        resetn_i = 1'b1;
        repeat (4) @(negedge mclk_i);
        chk(tx_mod_o, 1'b1);
        chk(miso_oe_o, 1'b0);
        // normal tx of three bytes with parity, crc and end marker
        crc = `NFCF_CRC_INIT;
        for (j = 0; j < 3; j = j + 1) begin
            b = nxt();
            host_u.xfer(b, r);
            addb(b);
            crcb(b);
        end
        addb(crc[15:8]);
        addb(crc[7:0]);
        repeat (3) eb.push_back(1'b1);
        go(13'h0003);
        to_low;
        repeat (8) @(negedge mclk_i);
        while (eb.size() > 0) begin
            chk(tx_mod_o, eb.pop_front());
            repeat (16) @(negedge mclk_i);
        end
        chk(tx_busy_o, 1'b0);
        // transparent: start refused, pins pass straight through
        mode_i = 2'h2;
        go(13'h0001);
        for (j = 0; j < 8; j = j + 1) begin
            b = nxt();
            mosi_t = b[0];
            rx_sub_i = b[1];
            repeat (6) @(negedge mclk_i);
            chk(tx_mod_o, mosi_t);
            chk(miso_o, rx_sub_i);
        end
        chk(tx_busy_o, 1'b0);
        i2c_en_i = 1'b1;
        repeat (3) @(negedge mclk_i);
        chk(miso_oe_o, 1'b0);
        i2c_en_i = 1'b0;
        // rx frame of 513 bytes at the fastest rate overflows the fifo
        rx_sub_i = 1'b1;
        mode_i = 2'h0;
        dir_tx_i = 1'b0;
        rate_i = 2'h3;
        repeat (8) @(negedge mclk_i);
        nrx = 0;
        for (j = 0; j < 513; j = j + 1) begin
            b = nxt();
            if (j < 512)
                fq.push_back(b);
            rxb({1'b1, ~^b, b, 1'b0});
        end
        for (k = 0; k < 40 && rx_eof_o !== 1'b1; k = k + 1)
            @(negedge mclk_i);
        chk(rx_eof_o, 1'b1);
        chk(nrx, 16'd513);
        chk(rx_overflow_o, 1'b1);
        rxb({1'b1, ^b, b, 1'b0});
        repeat (10) @(negedge mclk_i);
        chk(rx_par_err_o, 1'b1);
        for (j = 0; j < 3; j = j + 1) begin
            host_u.xfer(8'h00, r);
            chk(r, fq[2*j]);
        end
        // stream tx: bare data bits, lsb first
        dir_tx_i = 1'b1;
        mode_i = 2'h1;
        crc_en_i = 1'b0;
        rate_i = 2'h0;
        b = nxt() & 8'hfe;
        host_u.xfer(b, r);
        go(13'h0001);
        to_low;
        repeat (8) @(negedge mclk_i);
        for (j = 0; j < 8; j = j + 1) begin
            chk(tx_mod_o, b[j]);
            repeat (16) @(negedge mclk_i);
        end
        stop_test;
    end
endmodule // tb_nfcf_codec
